// ---- rtl/pfpc_pkg.sv ----
// Constants and types for the print format and position controller
package pfpc_pkg;
    localparam logic [7:0] A_CTRL = 8'h00;
    localparam logic [7:0] A_RXCHAR = 8'h04;
    localparam logic [7:0] A_HPITCH = 8'h08;
    localparam logic [7:0] A_HMARGIN = 8'h0c;
    localparam logic [7:0] A_VPITCH = 8'h10;
    localparam logic [7:0] A_FORMLEN = 8'h14;
    localparam logic [7:0] A_VMARGIN = 8'h18;
    localparam logic [7:0] A_HTAB = 8'h1c;
    localparam logic [7:0] A_VTAB = 8'h20;
    localparam logic [7:0] A_KEY = 8'h24;
    localparam logic [7:0] A_STATUS = 8'h28;
    localparam int TAB_SET_BIT = 8;
    localparam int TAB_ALL_BIT = 9;
    localparam int HCOLS = 217;
    localparam int VLINES = 168;
    // Pitch table in hundredths of characters per inch
    localparam logic [10:0] PITCH_TAB [8] = '{11'd500, 11'd600, 11'd825, 11'd1000,
                                              11'd1200, 11'd1320, 11'd1500, 11'd1650};
    localparam logic [19:0] WIDTH_TENTHS = 20'd132;
    localparam logic [19:0] TENTHS_X_HUND = 20'd1000;
    localparam logic [2:0] HPITCH_RST = 3'h3;
    localparam logic [2:0] VPITCH_RST = 3'h0;
    localparam logic [7:0] FORM_RST = 8'h42;
    localparam logic [7:0] POS_ONE = 8'h01;
    localparam logic [7:0] C_NUL = 8'h00, C_ETX = 8'h03, C_EOT = 8'h04, C_ENQ = 8'h05;
    localparam logic [7:0] C_BEL = 8'h07, C_BS = 8'h08, C_HT = 8'h09, C_LF = 8'h0a;
    localparam logic [7:0] C_VT = 8'h0b, C_FF = 8'h0c, C_CR = 8'h0d, C_DLE = 8'h10;
    localparam logic [7:0] C_CAN = 8'h18, C_SUB = 8'h1a, C_ESC = 8'h1b, C_DEL = 8'h7f;
    localparam logic [7:0] C_SP = 8'h20, C_LBRK = 8'h5b, C_ZERO = 8'h30, C_QM = 8'h3f;
    localparam logic [7:0] C_LC_C = 8'h63, C_SS3 = 8'h4f, C_TWO = 8'h32;
    localparam logic [7:0] C_COMMA = 8'h2c, C_MINUS = 8'h2d, C_DOT = 8'h2e;
    localparam logic [7:0] K_DIGIT_ALT = 8'h70, K_PUNCT_ALT = 8'h6c, K_ENTER_ALT = 8'h4d;
    localparam logic [7:0] K_FUNC = 8'h50;
    // Key codes: 0..9 digits, 10 comma, 11 minus, 12 period, 13 enter, 14..17 function keys
    localparam logic [4:0] KEY_COMMA = 5'd10, KEY_ENTER = 5'd13, KEY_FUNC1 = 5'd14, KEY_LAST = 5'd17;
    typedef enum logic [1:0] {DUP_FULL, DUP_HALF_ETX, DUP_HALF_EOT} pfpc_duplex_t;
    typedef enum logic [1:0] {ESC_IDLE, ESC_SEEN, ESC_CSI, ESC_CSI_ZERO} pfpc_esc_t;
    typedef struct packed {
        logic cr_newline;
        logic auto_disc;
        pfpc_duplex_t duplex;
        logic alt_keypad;
        logic lf_newline;
        logic auto_newline;
    } pfpc_ctrl_t;
    localparam pfpc_ctrl_t CTRL_RST = '{1'b0, 1'b1, DUP_FULL, 1'b0, 1'b0, 1'b1};
    typedef struct packed {
        logic [7:0] ch;
        logic [7:0] col;
        logic [7:0] line;
    } pfpc_print_t;
endpackage : pfpc_pkg

// ---- rtl/pfpc_top.sv ----
// Print format and position controller with Wishbone register access
// Operation
// - Eight pitches, freely mixed on a line
// - Pitch change rescales column by pitch ratio
// - Print only inside all four margins
// - Carriage return goes to left margin
// - Column below left margin clamps there
// - Past right margin: auto newline or bell
// - Horizontal margins need 1<=left<=right<=max
// - Max column is 13.2 times pitch
// - 217 independent idempotent horizontal tab stops
// - Vertical pitch keeps line, clears margins
// - Form length 1..168, clears margins, line one
// - Cleared margins: top one, bottom form length
// - Vertical margins need 1<=top<=bottom<=length
// - Line outside margins snaps to top margin
// - 168 independent idempotent vertical tab stops
// - Attributes request answers with identification reply
// - Keypad sends legends, or escape codes alternately
// - Function keys fixed; punctuation alternate codes
// - Unlisted control characters silently ignored
// - Null and delete discarded without effect
// - End of text turns line in mode
// - End of transmission: turnaround or disconnect
// - Newline mode: feeds also return column
// - Tab to next stop, else past margin
// - Vertical tab to next stop, else page
`timescale 1ns/1ps
module pfpc_top #(
    parameter int NUM_PITCH = 8
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic tx_ready_i,
    output logic tx_valid_o,
    output logic [7:0] tx_data_o,
    output logic print_valid_o,
    output pfpc_pkg::pfpc_print_t print_o,
    output logic bell_o,
    output logic turnaround_o,
    output logic disconnect_o,
    output logic answerback_o
);
    import pfpc_pkg::*;

    if (NUM_PITCH != 8) begin : g_pitch_chk
        $error("pfpc_top serves exactly eight pitches");
    end

    pfpc_ctrl_t ctrl;
    pfpc_esc_t esc_st, next_esc;
    logic [7:0] col, line, lm, rm, tm, bm, flen;
    logic [7:0] next_col, next_line, next_lm, next_rm, next_tm, next_bm, next_flen;
    logic [2:0] hp, vp, next_hp, next_vp;
    logic [HCOLS:1] htab;
    logic [VLINES:1] vtab;
    logic last_dle;
    logic [39:0] tx_buf;
    logic [2:0] tx_cnt;
    logic [39:0] seq;
    logic [2:0] seq_n;
    logic do_print, do_bell, do_turn, do_disc, do_enq, do_id;
    pfpc_print_t next_print;

    // Bus decode: one wait state, writes act when ack is raised
    logic req, wr;
    assign req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    assign wr = req & wb_we_i & wb_sel_i[0];
    logic [7:0] wd0, wd1;
    assign wd0 = wb_dat_i[7:0];
    assign wd1 = wb_dat_i[15:8];

    function automatic logic [7:0] max_col(input logic [2:0] idx);
        logic [19:0] p;
        p = {9'h000, PITCH_TAB[idx]} * WIDTH_TENTHS / TENTHS_X_HUND;
        return p[7:0];
    endfunction : max_col

    function automatic logic [7:0] htab_next(input logic [7:0] c);
        logic [7:0] r;
        r = rm + POS_ONE;
        for (int i = HCOLS; i >= 1; i--) begin
            if (htab[i] && i > int'(c) && i <= int'(rm)) r = 8'(i);
        end
        return r;
    endfunction : htab_next

    function automatic logic [7:0] vtab_next(input logic [7:0] l);
        logic [7:0] r;
        r = tm;
        for (int i = VLINES; i >= 1; i--) begin
            if (vtab[i] && i > int'(l) && i <= int'(bm)) r = 8'(i);
        end
        return r;
    endfunction : vtab_next

    function automatic logic [7:0] adv_line(input logic [7:0] l);
        return (l >= bm) ? tm : l + POS_ONE;
    endfunction : adv_line

    // Character interpreter and format commands
    always_comb begin
        logic [7:0] ch;
        logic [19:0] scaled;
        ch = wd0;
        scaled = '0;
        next_col = col;
        next_line = line;
        next_lm = lm;
        next_rm = rm;
        next_tm = tm;
        next_bm = bm;
        next_flen = flen;
        next_hp = hp;
        next_vp = vp;
        next_esc = esc_st;
        next_print = '{ch, col, line};
        do_print = 1'b0;
        do_bell = 1'b0;
        do_turn = 1'b0;
        do_disc = 1'b0;
        do_enq = 1'b0;
        do_id = 1'b0;
        if (wr && wb_adr_i == A_RXCHAR) begin
            if (esc_st != ESC_IDLE && ch >= C_SP && ch != C_DEL) begin
                next_esc = ESC_IDLE;
                if (esc_st == ESC_SEEN && ch == C_LBRK) begin
                    next_esc = ESC_CSI;
                end else if (esc_st == ESC_CSI && ch == C_ZERO) begin
                    next_esc = ESC_CSI_ZERO;
                end else if (esc_st != ESC_SEEN && ch == C_LC_C) begin
                    do_id = 1'b1;
                end
            end else begin
                case (ch)
                    C_NUL, C_DEL: ;
                    C_ETX: do_turn = ctrl.duplex == DUP_HALF_ETX;
                    C_EOT: begin
                        if (ctrl.duplex == DUP_HALF_EOT) begin
                            do_turn = ~last_dle;
                            do_disc = last_dle;
                        end else begin
                            do_disc = ctrl.auto_disc;
                        end
                    end
                    C_ENQ: do_enq = 1'b1;
                    C_BEL: do_bell = 1'b1;
                    C_BS: if (col > lm) next_col = col - POS_ONE;
                    C_HT: next_col = htab_next(col);
                    C_LF: begin
                        next_line = adv_line(line);
                        if (ctrl.lf_newline) next_col = lm;
                    end
                    C_VT: begin
                        next_line = vtab_next(line);
                        if (ctrl.lf_newline) next_col = lm;
                    end
                    C_FF: begin
                        next_line = tm;
                        if (ctrl.lf_newline) next_col = lm;
                    end
                    C_CR: begin
                        next_col = lm;
                        if (ctrl.cr_newline) next_line = adv_line(line);
                    end
                    C_CAN, C_SUB: next_esc = ESC_IDLE;
                    C_ESC: next_esc = ESC_SEEN;
                    default: begin
                        if (ch >= C_SP) begin
                            if (col > rm) begin
                                if (ctrl.auto_newline) begin
                                    next_line = adv_line(line);
                                    next_print = '{ch, lm, next_line};
                                    next_col = lm + POS_ONE;
                                    do_print = 1'b1;
                                end else begin
                                    do_bell = 1'b1;
                                end
                            end else begin
                                do_print = 1'b1;
                                next_col = col + POS_ONE;
                            end
                        end
                    end
                endcase
            end
        end else if (wr && wb_adr_i == A_HPITCH) begin
            next_hp = wb_dat_i[2:0];
            scaled = 20'(col - POS_ONE) * {9'h000, PITCH_TAB[hp]}
                / {9'h000, PITCH_TAB[wb_dat_i[2:0]]};
            next_col = scaled[7:0] + POS_ONE;
        end else if (wr && wb_adr_i == A_HMARGIN) begin
            if (wd0 >= POS_ONE && wd0 <= wd1 && wd1 <= max_col(hp)) begin
                next_lm = wd0;
                next_rm = wd1;
            end
        end else if (wr && wb_adr_i == A_VPITCH) begin
            next_vp = wb_dat_i[2:0];
            next_tm = POS_ONE;
            next_bm = flen;
        end else if (wr && wb_adr_i == A_FORMLEN) begin
            if (wd0 >= POS_ONE && wd0 <= 8'(VLINES)) begin
                next_flen = wd0;
                next_tm = POS_ONE;
                next_bm = wd0;
                next_line = POS_ONE;
            end
        end else if (wr && wb_adr_i == A_VMARGIN) begin
            if (wd0 >= POS_ONE && wd0 <= wd1 && wd1 <= flen) begin
                next_tm = wd0;
                next_bm = wd1;
            end
        end
        if (next_col < next_lm) next_col = next_lm;
        if (next_line < next_tm || next_line > next_bm) next_line = next_tm;
    end

    // Position and format state
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            col <= POS_ONE;
            line <= POS_ONE;
            hp <= HPITCH_RST;
            vp <= VPITCH_RST;
            flen <= FORM_RST;
            lm <= POS_ONE;
            rm <= max_col(HPITCH_RST);
            tm <= POS_ONE;
            bm <= FORM_RST;
            esc_st <= ESC_IDLE;
            last_dle <= 1'b0;
        end else begin
            col <= next_col;
            line <= next_line;
            hp <= next_hp;
            vp <= next_vp;
            flen <= next_flen;
            lm <= next_lm;
            rm <= next_rm;
            tm <= next_tm;
            bm <= next_bm;
            esc_st <= next_esc;
            if (wr && wb_adr_i == A_RXCHAR && wd0 != C_NUL && wd0 != C_DEL) begin
                last_dle <= wd0 == C_DLE;
            end
        end
    end

    // Tab stops
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            htab <= '0;
            vtab <= '0;
        end else if (wr && wb_adr_i == A_HTAB) begin
            if (wb_dat_i[TAB_ALL_BIT]) begin
                htab <= '0;
            end else if (wd0 >= POS_ONE && wd0 <= 8'(HCOLS)) begin
                htab[wd0] <= wb_dat_i[TAB_SET_BIT];
            end
        end else if (wr && wb_adr_i == A_VTAB) begin
            if (wb_dat_i[TAB_ALL_BIT]) begin
                vtab <= '0;
            end else if (wd0 >= POS_ONE && wd0 <= 8'(VLINES)) begin
                vtab[wd0] <= wb_dat_i[TAB_SET_BIT];
            end
        end
    end

    // Control register
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl <= CTRL_RST;
        end else if (wr && wb_adr_i == A_CTRL) begin
            ctrl <= pfpc_ctrl_t'(wb_dat_i[6:0]);
        end
    end

    // Event outputs
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            print_valid_o <= 1'b0;
            print_o <= '0;
            bell_o <= 1'b0;
            turnaround_o <= 1'b0;
            disconnect_o <= 1'b0;
            answerback_o <= 1'b0;
        end else begin
            print_valid_o <= do_print;
            if (do_print) print_o <= next_print;
            bell_o <= do_bell;
            turnaround_o <= do_turn;
            disconnect_o <= do_disc;
            answerback_o <= do_enq;
        end
    end

    // Transmit sequences for identification and keys
    always_comb begin
        logic [4:0] k;
        logic [7:0] alt;
        k = wb_dat_i[4:0];
        alt = '0;
        seq = '0;
        seq_n = '0;
        if (do_id) begin
            seq = {C_ESC, C_LBRK, C_QM, C_TWO, C_LC_C};
            seq_n = 3'd5;
        end else if (wr && wb_adr_i == A_KEY && k <= KEY_LAST) begin
            if (k >= KEY_FUNC1) begin
                alt = K_FUNC + 8'(k - KEY_FUNC1);
            end else if (k == KEY_ENTER) begin
                alt = K_ENTER_ALT;
            end else if (k >= KEY_COMMA) begin
                alt = K_PUNCT_ALT + 8'(k - KEY_COMMA);
            end else begin
                alt = K_DIGIT_ALT + 8'(k);
            end
            if (ctrl.alt_keypad || k >= KEY_FUNC1) begin
                seq = {C_ESC, C_SS3, alt, 16'h0000};
                seq_n = 3'd3;
            end else begin
                seq_n = 3'd1;
                if (k == KEY_ENTER) seq[39:32] = C_CR;
                else if (k >= KEY_COMMA) seq[39:32] = C_COMMA + 8'(k - KEY_COMMA);
                else seq[39:32] = C_ZERO + 8'(k);
            end
        end
    end

    assign tx_data_o = tx_buf[39:32];

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            tx_buf <= '0;
            tx_cnt <= '0;
            tx_valid_o <= 1'b0;
        end else if (!tx_valid_o) begin
            if (seq_n != 3'd0) begin
                tx_buf <= seq;
                tx_cnt <= seq_n;
                tx_valid_o <= 1'b1;
            end
        end else if (tx_ready_i) begin
            tx_buf <= {tx_buf[31:0], 8'h00};
            tx_cnt <= tx_cnt - 3'd1;
            tx_valid_o <= tx_cnt > 3'd1;
        end
    end

    // Wishbone answer and read data
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= '0;
        end else begin
            wb_ack_o <= req;
            wb_dat_o <= '0;
            if (req && !wb_we_i) begin
                if (wb_adr_i == A_CTRL) begin
                    wb_dat_o <= {25'h0000000, ctrl};
                end else if (wb_adr_i == A_HPITCH) begin
                    wb_dat_o <= {21'h000000, max_col(hp), hp};
                end else if (wb_adr_i == A_HMARGIN) begin
                    wb_dat_o <= {16'h0000, rm, lm};
                end else if (wb_adr_i == A_VPITCH) begin
                    wb_dat_o <= {29'h00000000, vp};
                end else if (wb_adr_i == A_FORMLEN) begin
                    wb_dat_o <= {24'h000000, flen};
                end else if (wb_adr_i == A_VMARGIN) begin
                    wb_dat_o <= {16'h0000, bm, tm};
                end else if (wb_adr_i == A_STATUS) begin
                    wb_dat_o <= {15'h0000, tx_valid_o, line, col};
                end
            end
        end
    end
endmodule : pfpc_top

// ---- sim/pfpc_host.sv ----
// Host-side model: sink for the bytes that the terminal transmits
`timescale 1ns/1ps
module pfpc_host (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic stall_i,
    input wire logic tx_valid_i,
    input wire logic [7:0] tx_data_i,
    output logic tx_ready_o
);
    logic [7:0] q[$];
    logic [1:0] cnt;
    // Slow mode takes one cycle in four
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cnt <= 2'h0;
            tx_ready_o <= 1'b0;
        end else begin
            cnt <= cnt + 2'h1;
            tx_ready_o <= !stall_i || cnt == 2'h3;
        end
    end
    always @(posedge clk_i) begin
        if (!rst_i && tx_valid_i === 1'b1 && tx_ready_o) q.push_back(tx_data_i);
    end
endmodule : pfpc_host

// ---- sim/pfpc_top_chk.sv ----
// Port checks for the format and position controller
`timescale 1ns/1ps
module pfpc_top_chk #(
    parameter int NUM_PITCH = 8
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire logic tx_ready_i,
    input wire logic tx_valid_o,
    input wire logic [7:0] tx_data_o,
    input wire logic print_valid_o,
    input wire pfpc_pkg::pfpc_print_t print_o,
    input wire logic bell_o,
    input wire logic turnaround_o,
    input wire logic disconnect_o,
    input wire logic answerback_o
);
    import pfpc_pkg::*;
    pfpc_duplex_t dup;
    logic adisc;
    logic req;
    logic wr;
    assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign wr = req && wb_we_i && wb_sel_i[0];
    // Mirror of the duplex and disconnect options
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dup <= DUP_FULL;
            adisc <= 1'b1;
        end else if (wr && wb_adr_i == A_CTRL) begin
            dup <= pfpc_duplex_t'(wb_dat_i[4:3]);
            adisc <= wb_dat_i[5];
        end
    end
    function automatic logic known(input logic [7:0] c);
        return c inside {8'h00, [8'h03:8'h05], [8'h07:8'h10], 8'h18, 8'h1a, 8'h1b};
    endfunction : known
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    sequence rx_char(logic [7:0] c);
        wr && wb_adr_i == A_RXCHAR && wb_dat_i[7:0] == c;
    endsequence
    sequence quiet;
        !print_valid_o && !bell_o && !turnaround_o && !disconnect_o && !answerback_o;
    endsequence
    a_ack_one_wait: assert property (req |=> wb_ack_o ##1 !wb_ack_o)
        else $error("ack not one pulse after request");
    a_dat_idle_zero: assert property ((!wb_ack_o || wb_we_i) |-> wb_dat_o == 32'h0)
        else $error("read data outside a read");
    a_reset_quiet: assert property ($fell(rst_i) |-> !tx_valid_o && !print_valid_o && !wb_ack_o)
        else $error("outputs active after reset");
    a_fill_quiet: assert property ((rx_char(C_NUL) or rx_char(C_DEL)) |=> quiet)
        else $error("fill character had an effect");
    a_unknown_ctrl: assert property (wr && wb_adr_i == A_RXCHAR && wb_dat_i[7:0] < C_SP
        && !known(wb_dat_i[7:0]) |=> quiet) else $error("unlisted control acted");
    a_etx_turn: assert property (rx_char(C_ETX) |=> turnaround_o == (dup == DUP_HALF_ETX) && !disconnect_o)
        else $error("end of text handled wrongly");
    a_eot_disc: assert property (rx_char(C_EOT) ##0 dup != DUP_HALF_EOT |=> disconnect_o == adisc)
        else $error("end of transmission disconnect wrong");
    a_eot_turn: assert property (rx_char(C_EOT) ##0 dup == DUP_HALF_EOT |=> turnaround_o ^ disconnect_o)
        else $error("end of transmission turnaround wrong");
    a_tx_hold: assert property (tx_valid_o && !tx_ready_i |=> tx_valid_o && $stable(tx_data_o))
        else $error("tx byte dropped before accepted");
    a_print_cause: assert property (print_valid_o |-> wb_ack_o && print_o.col != 8'h0)
        else $error("print without received character");
    a_func_escape: assert property (wr && wb_adr_i == A_KEY && wb_dat_i[4:0] >= KEY_FUNC1
        && !tx_valid_o |=> tx_valid_o && tx_data_o == C_ESC) else $error("function key not escape");
endmodule : pfpc_top_chk
bind pfpc_top pfpc_top_chk #(.NUM_PITCH(NUM_PITCH)) chk_u (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .tx_ready_i(tx_ready_i), .tx_valid_o(tx_valid_o),
    .tx_data_o(tx_data_o), .print_valid_o(print_valid_o), .print_o(print_o), .bell_o(bell_o),
    .turnaround_o(turnaround_o), .disconnect_o(disconnect_o), .answerback_o(answerback_o));

// ---- sim/pfpc_bench.sv ----
// Self-checking bench for the format and position controller
`timescale 1ns/1ps
module pfpc_bench;
    import pfpc_pkg::*;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cyc = 1'b0;
    logic we = 1'b0;
    logic stall = 1'b0;
    logic [3:0] sel = 4'h1;
    logic [7:0] adr = 8'h0;
    logic [31:0] wdat = 32'h0;
    logic [31:0] dat_o, rd, pos;
    logic ack, tx_ready, tx_valid, pv, bell, turn, disc, ansb;
    logic [7:0] tx_data;
    logic [4:0] ev;
    pfpc_print_t pr, lp;
    logic [7:0] e[$];
    int fail_count = 0;
    int num_checks = 0;
    pfpc_top dut_u (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr),
        .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(dat_o), .wb_ack_o(ack), .tx_ready_i(tx_ready),
        .tx_valid_o(tx_valid), .tx_data_o(tx_data), .print_valid_o(pv), .print_o(pr), .bell_o(bell),
        .turnaround_o(turn), .disconnect_o(disc), .answerback_o(ansb));
    pfpc_host host_u (.clk_i(clk_i), .rst_i(rst_i), .stall_i(stall), .tx_valid_i(tx_valid),
        .tx_data_i(tx_data), .tx_ready_o(tx_ready));
    initial begin
        forever #5 clk_i = ~clk_i;
    end
    task automatic end_sim();
        if (fail_count == 0 && num_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : end_sim
    task automatic chk(input logic ok, input string m);
        num_checks++;
        if (ok !== 1'b1) begin
            fail_count++;
            $display("[ERR] %0t %s", $time, m);
        end
    endtask : chk
    // One classic cycle; events are taken with the ack
    task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n = 0;
        cyc <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        @(posedge clk_i);
        while (ack !== 1'b1 && n < 20) begin
            @(posedge clk_i);
            n++;
        end
        if (n == 20) begin
            chk(1'b0, "bus timeout");
            end_sim();
        end
        rd = dat_o;
        ev = {ansb, disc, turn, bell, pv};
        lp = pr;
        cyc <= 1'b0;
        we <= 1'b0;
        @(posedge clk_i);
    endtask : acc
    task automatic ch(input logic [7:0] c);
        acc(1'b1, A_RXCHAR, {24'h0, c});
    endtask : ch
    task automatic rc(input logic [7:0] a, input logic [31:0] x);
        acc(1'b0, a, 32'h0);
        chk(rd === x, "register readback");
    endtask : rc
    task automatic st(input logic [7:0] col, input logic [7:0] line);
        acc(1'b0, A_STATUS, 32'h0);
        chk(rd[15:0] === {line, col}, "active position");
    endtask : st
    task automatic tx_chk();
        int n = 0;
        while ((host_u.q.size() != e.size() || tx_valid !== 1'b0) && n < 200) begin
            @(posedge clk_i);
            n++;
        end
        if (n == 200) begin
            chk(1'b0, "tx timeout");
            end_sim();
        end
        chk(host_u.q.size() == e.size(), "tx byte count");
        foreach (e[i]) if (i < host_u.q.size()) chk(host_u.q[i] === e[i], "tx byte");
        host_u.q.delete();
    endtask : tx_chk
    initial begin
        repeat (12) @(posedge clk_i);
        rst_i <= 1'b0;
        st(8'd1, 8'd1);
        rc(A_HMARGIN, 32'h8401);
        rc(A_VMARGIN, 32'h4201);
        rc(8'h2c, 32'h0);
        for (int i = 0; i < 8; i++) begin
            acc(1'b1, A_HPITCH, 32'(i));
            rc(A_HPITCH, {21'h0, 8'((132 * PITCH_TAB[i]) / 1000), 3'(i)});
        end
        acc(1'b1, A_HPITCH, 32'h3);
        repeat (40) ch(C_SP);
        acc(1'b1, A_HPITCH, 32'h7);
        st(8'd25, 8'd1);
        acc(1'b1, A_HPITCH, 32'h3);
        st(8'd40, 8'd1);
        acc(1'b1, A_HMARGIN, 32'h0a05);
        acc(1'b1, A_HMARGIN, 32'h0a00);
        acc(1'b1, A_HMARGIN, 32'h8505);
        acc(1'b1, A_HMARGIN, 32'h0409);
        sel <= 4'h2;
        acc(1'b1, A_HMARGIN, 32'h0b07);
        sel <= 4'h1;
        rc(A_HMARGIN, 32'h0a05);
        ch(C_CR);
        st(8'd5, 8'd1);
        ch(C_BS);
        st(8'd5, 8'd1);
        ch(8'h41);
        chk(ev[0] === 1'b1 && lp.col === 8'd5 && lp.ch === 8'h41, "print at margin");
        repeat (5) ch(8'h42);
        ch(8'h43);
        chk(ev[0] === 1'b1 && lp.col === 8'd5 && lp.line === 8'd2, "auto newline");
        acc(1'b1, A_CTRL, 32'h20);
        repeat (5) ch(8'h42);
        ch(8'h43);
        chk(ev[1:0] === 2'b10, "bell and discard");
        st(8'd11, 8'd2);
        ch(C_CR);
        acc(1'b1, A_HTAB, 32'h108);
        acc(1'b1, A_HTAB, 32'h108);
        acc(1'b1, A_HTAB, 32'h107);
        acc(1'b1, A_HTAB, 32'h007);
        ch(C_HT);
        st(8'd8, 8'd2);
        ch(C_HT);
        st(8'd11, 8'd2);
        acc(1'b1, A_CTRL, 32'h23);
        ch(C_LF);
        st(8'd5, 8'd3);
        acc(1'b1, A_FORMLEN, 32'h0);
        acc(1'b1, A_FORMLEN, 32'd169);
        rc(A_FORMLEN, 32'h42);
        acc(1'b1, A_FORMLEN, 32'd10);
        rc(A_VMARGIN, 32'h0a01);
        st(8'd5, 8'd1);
        acc(1'b1, A_VMARGIN, 32'h0b02);
        acc(1'b1, A_VMARGIN, 32'h0500);
        rc(A_VMARGIN, 32'h0a01);
        acc(1'b1, A_VMARGIN, 32'h0501);
        repeat (4) ch(C_LF);
        acc(1'b1, A_VMARGIN, 32'h0502);
        ch(C_LF);
        st(8'd5, 8'd2);
        acc(1'b1, A_VTAB, 32'h104);
        acc(1'b1, A_VTAB, 32'h104);
        acc(1'b1, A_VTAB, 32'h103);
        acc(1'b1, A_VTAB, 32'h003);
        ch(C_VT);
        st(8'd5, 8'd4);
        ch(C_VT);
        st(8'd5, 8'd2);
        acc(1'b1, A_VPITCH, 32'h1);
        rc(A_VMARGIN, 32'h0a01);
        st(8'd5, 8'd2);
        acc(1'b0, A_STATUS, 32'h0);
        pos = rd;
        e = '{C_NUL, C_DEL, 8'h01, 8'h1f};
        foreach (e[i]) begin
            ch(e[i]);
            chk(ev === 5'h0, "ignored character acted");
        end
        rc(A_STATUS, pos);
        e = '{C_ESC, C_LBRK, C_QM, C_TWO, C_LC_C};
        ch(C_ESC);
        ch(C_LBRK);
        ch(C_LC_C);
        tx_chk();
        ch(C_ESC);
        ch(C_LBRK);
        ch(C_ZERO);
        ch(C_LC_C);
        tx_chk();
        for (int a = 0; a < 2; a++) begin
            acc(1'b1, A_CTRL, 32'h21 | 32'(a << 2));
            for (int k = 0; k < 18; k++) begin
                stall <= k[0];
                if (k >= 14) e = '{C_ESC, C_SS3, 8'(K_FUNC + k - 14)};
                else if (a == 0) e = '{k == 13 ? C_CR : 8'(k < 10 ? C_ZERO + k : C_COMMA + k - 10)};
                else e = '{C_ESC, C_SS3, k == 13 ? K_ENTER_ALT : 8'(k < 10 ? K_DIGIT_ALT + k : K_PUNCT_ALT + k - 10)};
                acc(1'b1, A_KEY, 32'(k));
                tx_chk();
            end
        end
        for (int d = 0; d < 3; d++) begin
            acc(1'b1, A_CTRL, 32'h21 | 32'(d << 3));
            ch(C_ETX);
            chk(ev[3:2] === {1'b0, d == 1}, "end of text");
            ch(C_EOT);
            chk(ev[3:2] === (d == 2 ? 2'b01 : 2'b10), "end of transmission");
        end
        ch(C_DLE);
        ch(C_EOT);
        chk(ev[3:2] === 2'b10, "escaped end of transmission");
        acc(1'b1, A_CTRL, 32'h01);
        ch(C_EOT);
        chk(ev[3:2] === 2'b00, "disconnect while off");
        acc(1'b1, A_CTRL, 32'h41);
        ch(C_ENQ);
        chk(ev === 5'h10, "answerback");
        ch(C_CR);
        st(8'd5, 8'd3);
        acc(1'b1, A_HTAB, 32'h200);
        ch(C_HT);
        st(8'd11, 8'd3);
        acc(1'b1, A_VTAB, 32'h200);
        ch(C_VT);
        st(8'd11, 8'd1);
        end_sim();
    end
endmodule : pfpc_bench
